// file: design/ebs_bus_master.sv
// Expansion bus master: strobes, chip selects, data and wait stall.
// Assumes the core holds i_req stable while o_req_ready is low, and that
// the bus clock runs whenever an access is outstanding.
`timescale 1ns/100ps
module ebs_bus_master #(
  parameter int STROBE_CYCLES = ebs_pkg::STROBE_CYC  // Strobe width, cycles
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst_b,
  input  wire logic                          i_req_valid,
  input  wire ebs_pkg::ebs_req_t             i_req,
  output logic                               o_req_ready,
  output logic                               o_done,
  output logic [ebs_pkg::DATA_W-1:0]         o_rdata,
  input  wire logic                          i_bus_clock_in,
  output logic [ebs_pkg::CS_N-1:0]           o_bus_select_n,
  output logic                               o_bus_read_strobe_n,
  output logic                               o_bus_write_strobe_n,
  output logic                               o_bus_addr_latch,
  input  wire logic [ebs_pkg::DATA_W-1:0]    i_bus_data,
  output logic [ebs_pkg::DATA_W-1:0]         o_bus_data,
  output logic                               o_bus_data_oe,
  input  wire logic                          i_bus_wait_n
);
  import ebs_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // Core clock side: hold the request, toggle to hand it over
  ebs_req_t          req;        // Request held for the link side
  logic              req_tgl;    // Flips once per handed-over request
  logic              busy;       // An access is outstanding
  logic [2:0]        done_sync;  // Done toggle synchroniser plus edge stage
  ebs_req_t          next_req;
  logic              next_req_tgl, next_busy, next_done;
  logic [DATA_W-1:0] next_rdata;
  logic              done_tgl;   // Link side: flips when an access ends
  logic [DATA_W-1:0] link_rdata; // Link side: read word, stable at toggle

  // Next values for the core side
  always_comb begin
    next_req     = req;
    next_req_tgl = req_tgl;
    next_busy    = busy;
    next_done    = 1'b0;
    next_rdata   = o_rdata;
    if (!busy && i_req_valid) begin
      // Take a new request only when nothing is in flight
      next_req     = i_req;
      next_req_tgl = ~req_tgl;
      next_busy    = 1'b1;
    end else if (busy && (done_sync[2] != done_sync[1])) begin
      // Read word is stable on the link side once the toggle is seen
      next_busy  = 1'b0;
      next_done  = 1'b1;
      next_rdata = link_rdata;
    end
  end

  // Core side registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      req         <= '0;
      req_tgl     <= 1'b0;
      busy        <= 1'b0;
      done_sync   <= '0;
      o_done      <= 1'b0;
      o_rdata     <= '0;
      o_req_ready <= 1'b0;
    end else begin
      req         <= next_req;
      req_tgl     <= next_req_tgl;
      busy        <= next_busy;
      done_sync   <= {done_sync[1:0], done_tgl};
      o_done      <= next_done;
      o_rdata     <= next_rdata;
      o_req_ready <= ~next_busy;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Link reset: asserts at once, releases on the bus clock
  logic [1:0] link_rst_sync;  // Release synchroniser
  logic       link_rst_b;     // Reset of the bus clock domain
  // Async clear, synchronous release to avoid a partial first edge
  always_ff @(posedge i_bus_clock_in or negedge i_rst_b) begin
    if (!i_rst_b) begin
      link_rst_sync <= 2'b00;
    end else begin
      link_rst_sync <= {link_rst_sync[0], 1'b1};
    end
  end
  assign link_rst_b = link_rst_sync[1];
  ////////////////////////////////////////////////////////////////////////////
  // Link side: synchronisers on the bus clock
  logic [2:0] req_sync;   // Request toggle synchroniser plus edge stage
  logic [1:0] wait_sync;  // Wait pin synchroniser
  logic       req_seen;   // New request arrived this cycle
  logic       wait_low;   // Synchronised wait is asserted
  // Two flops before any logic reads the pin or the toggle
  always_ff @(posedge i_bus_clock_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      req_sync  <= '0;
      wait_sync <= 2'b11;
    end else begin
      req_sync  <= {req_sync[1:0], req_tgl};
      wait_sync <= {wait_sync[0], i_bus_wait_n};
    end
  end
  assign req_seen = req_sync[2] != req_sync[1];
  assign wait_low = !wait_sync[1];
  ////////////////////////////////////////////////////////////////////////////
  // Link side: access sequencer
  typedef enum logic [1:0] {
    L_IDLE,     // Bus parked
    L_ADDR,     // Address latch phase
    L_STROBE,   // Strobe asserted, may stall on wait
    L_RECOVER   // Strobes released, select held until leaving
  } ebs_state_t;
  ebs_state_t        state, next_state;
  ebs_req_t          cur, next_cur;             // Access being run
  logic [CNT_W-1:0]  cnt, next_cnt;             // Strobe cycles spent
  logic [CS_N-1:0]   next_select_n;
  logic              next_rd_n, next_wr_n, next_ale, next_oe;
  logic [DATA_W-1:0] next_data, next_link_rdata;
  logic              next_done_tgl;
  logic              stall;                     // Access frozen this cycle
  // Styles other than the separate and combined ones ignore wait
  assign stall = (state == L_STROBE) && (cur.style != STYLE_SYNC) &&
                 wait_low;
  // Drive strobes for the strobe phase of access a
  task automatic start_strobe(input ebs_req_t a);
    next_state = L_STROBE;
    next_cnt   = '0;
    next_ale   = 1'b0;
    // Combined style: read strobe is the data strobe, write is a level
    next_rd_n  = (a.style == STYLE_COMBINED) ? 1'b0 : a.write;
    next_wr_n  = ~a.write;
    // Drive data only for writes, release it for reads
    next_oe   = a.write;
    next_data = a.wdata;
  endtask

  // Next values for the link side
  always_comb begin
    next_state      = state;
    next_cur        = cur;
    next_cnt        = cnt;
    next_select_n   = o_bus_select_n;
    next_rd_n       = o_bus_read_strobe_n;
    next_wr_n       = o_bus_write_strobe_n;
    next_ale        = o_bus_addr_latch;
    next_oe         = o_bus_data_oe;
    next_data       = o_bus_data;
    next_link_rdata = link_rdata;
    next_done_tgl   = done_tgl;
    case (state)
      L_IDLE: begin
        next_ale = 1'b0;
        if (req_seen) begin
          next_cur      = req;
          // One select per access, decoded from its index
          next_select_n = ~(CS_ONE << req.cs);
          if (req.muxed || (req.style == STYLE_SYNC)) begin
            // Latch or address-valid phase first
            next_state = L_ADDR;
            next_ale   = 1'b1;
            next_oe    = 1'b1;
            next_data  = req.addr;
          end else begin
            start_strobe(req);
          end
        end
      end
      L_ADDR: begin
        start_strobe(cur);
      end
      L_STROBE: begin
        if (stall) begin
          // Freeze counter and pins until wait rises
          next_cnt = cnt;
        end else if (cnt == CNT_W'(STROBE_CYCLES - 1)) begin
          // Read data sampled on the bus clock at strobe end
          if (!cur.write) begin
            next_link_rdata = i_bus_data;
          end
          next_rd_n  = 1'b1;
          next_wr_n  = 1'b1;
          next_state = L_RECOVER;
        end else begin
          // Continue from the held count, never restart
          next_cnt = cnt + CNT_W'(1);
        end
      end
      L_RECOVER: begin
        // Park the bus high again and report the end of access
        next_select_n = CS_IDLE;
        next_oe       = 1'b1;
        next_data     = DATA_PARK;
        next_done_tgl = ~done_tgl;
        next_state    = L_IDLE;
      end
      default: begin
        next_state = L_IDLE;
      end
    endcase
  end

  // Link side registers; all pins launched on the bus clock
  always_ff @(posedge i_bus_clock_in or negedge link_rst_b) begin
    if (!link_rst_b) begin
      // Strobes, selects and data held high in reset
      state                <= L_IDLE;
      cur                  <= '0;
      cnt                  <= '0;
      o_bus_select_n       <= CS_IDLE;
      o_bus_read_strobe_n  <= 1'b1;
      o_bus_write_strobe_n <= 1'b1;
      o_bus_addr_latch     <= 1'b1;
      o_bus_data_oe        <= 1'b1;
      o_bus_data           <= DATA_PARK;
      link_rdata           <= '0;
      done_tgl             <= 1'b0;
    end else begin
      state                <= next_state;
      cur                  <= next_cur;
      cnt                  <= next_cnt;
      o_bus_select_n       <= next_select_n;
      o_bus_read_strobe_n  <= next_rd_n;
      o_bus_write_strobe_n <= next_wr_n;
      o_bus_addr_latch     <= next_ale;
      o_bus_data_oe        <= next_oe;
      o_bus_data           <= next_data;
      link_rdata           <= next_link_rdata;
      done_tgl             <= next_done_tgl;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bus clock domain
  sequence stalled_s;
    state == L_STROBE && stall;
  endsequence
  sequence resumed_s;
    state == L_STROBE && !stall && cnt != CNT_W'(STROBE_CYCLES - 1);
  endsequence
  select_one_hot_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    $onehot0(~o_bus_select_n))
    else $error("More than one chip select asserted");
  read_released_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    (state == L_STROBE && !cur.write) |-> !o_bus_data_oe)
    else $error("Data driven during a read strobe");
  reset_park_a: assert property (
    @(posedge i_bus_clock_in)
    $rose(link_rst_b) |-> o_bus_read_strobe_n && o_bus_write_strobe_n &&
      o_bus_select_n == CS_IDLE && o_bus_data == DATA_PARK)
    else $error("Bus pins not high out of reset");
  stall_hold_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    stalled_s |=> state == L_STROBE && $stable(cnt) &&
      $stable(o_bus_read_strobe_n) && $stable(o_bus_select_n))
    else $error("Access moved while stalled");
  resume_point_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    stalled_s ##1 resumed_s |=> cnt == $past(cnt) + CNT_W'(1))
    else $error("Access did not resume from held point");
  // In the synchronous style the count must keep moving whatever the wait pin does
  sync_ignores_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    (state == L_STROBE && cur.style == STYLE_SYNC) |=>
      state != L_STROBE || cnt == $past(cnt) + CNT_W'(1))
    else $error("Synchronous style stalled on wait");
  latch_phase_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    state == L_ADDR |-> o_bus_addr_latch && o_bus_data == cur.addr
      ##1 !o_bus_addr_latch)
    else $error("Address latch phase wrong");
  write_strobe_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    (state == L_STROBE && cur.write && cur.style == STYLE_SEPARATE) |->
      !o_bus_write_strobe_n && o_bus_read_strobe_n && o_bus_data_oe)
    else $error("Write strobe missing on write");
  // Pin low at one edge reaches the sequencer two edges later
  wait_latency_a: assert property (
    @(posedge i_bus_clock_in) disable iff (!link_rst_b)
    !i_bus_wait_n ##2 (state == L_STROBE && cur.style != STYLE_SYNC)
      |=> state == L_STROBE)
    else $error("Wait low did not stall two cycles later");
endmodule

// file: design/ebs_pkg.sv
// Package for the expansion bus strobe and wait block.
// Assumes the core clock and the expansion bus clock are unrelated.
package ebs_pkg;
  localparam int          DATA_W      = 16;       // Width of the data path
  localparam int          CS_N        = 4;        // Number of chip selects
  localparam int          CS_IDX_W    = 2;        // Bits to pick one select
  localparam logic [15:0] DATA_PARK   = 16'hFFFF; // Level while parked/reset
  localparam logic [3:0]  CS_IDLE     = 4'hF;     // No select asserted
  localparam logic [3:0]  CS_ONE      = 4'h1;     // Seed for select decode
  localparam int          LINK_NS     = 125;      // Bus clock period, ns
  localparam int          STROBE_NS   = 250;      // Least strobe width, ns
  // Least time rounds up to whole bus clock cycles
  localparam int          STROBE_CYC  = (STROBE_NS + LINK_NS - 1) / LINK_NS;
  localparam int          CNT_W       = 4;        // Strobe counter width

  // Timing style of the selected chip select
  typedef enum logic [1:0] {
    STYLE_SEPARATE,   // Separate read and write strobes, obeys wait
    STYLE_COMBINED,   // One data strobe plus read/write level, obeys wait
    STYLE_SYNC        // Synchronous device style, ignores wait
  } ebs_style_t;

  // One outbound access as handed over by the core
  typedef struct packed {
    logic                write;  // High for a write access
    logic                muxed;  // Address rides the data lines first
    logic [CS_IDX_W-1:0] cs;     // Which chip select to assert
    ebs_style_t          style;  // Timing style of that select
    logic [DATA_W-1:0]   addr;   // Address word for the latch phase
    logic [DATA_W-1:0]   wdata;  // Write data
  } ebs_req_t;
endpackage

// file: testbench/ebs_periph_model.sv
// Peripheral on the far side of the expansion bus.
// Assumes the bench hands it the master's pins; it returns the data wire.
`timescale 1ns/100ps
module ebs_periph_model (
  input  wire logic        i_bus_clock_in,
  input  wire logic [3:0]  i_select_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic        i_addr_latch,
  input  wire logic [15:0] i_data_out,
  input  wire logic        i_data_oe,
  input  wire logic [15:0] i_rd_word,
  input  wire logic [7:0]  i_stall_len,
  output logic      [15:0] o_data_pins,
  output logic             o_wait_n,
  output logic      [7:0]  o_strobe_cycles,
  output logic      [3:0]  o_select_seen,
  output logic      [15:0] o_write_seen,
  output logic      [15:0] o_addr_seen
);
  logic [7:0]  run;   // Strobe low cycles so far
  logic [7:0]  wcnt;  // Wait cycles still to hold
  logic [15:0] last;  // Last level on the wire
  logic        drive; // Peripheral drives the data wire

  // Drive only on a read, so the two ends never fight
  assign drive = (i_select_n != 4'hF) && !i_read_strobe_n
                 && i_write_strobe_n;
  // A released wire shows the inverse of its last level, not a stale copy
  assign o_data_pins = i_data_oe ? i_data_out
                     : drive ? i_rd_word : ~last;
  // Pulled up by the board unless a stall is commanded
  assign o_wait_n = (wcnt == 8'h00);

  initial begin
    run = 8'h00;
    wcnt = 8'h00;
    last = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  // Everything is sampled on the bus clock
  always @(posedge i_bus_clock_in) begin
    last <= o_data_pins;
    if (wcnt != 8'h00) begin
      wcnt <= wcnt - 8'h01;
    end
    if (!i_read_strobe_n) begin
      run <= run + 8'h01;
      o_select_seen <= i_select_n;
      // Stall from the second strobe cycle on
      if (run == 8'h00 && i_stall_len != 8'h00) begin
        wcnt <= i_stall_len;
      end
    end else if (run != 8'h00) begin
      o_strobe_cycles <= run;
      run <= 8'h00;
    end
    if (!i_write_strobe_n && i_data_oe) begin
      o_write_seen <= i_data_out;
    end
    if (i_addr_latch && i_select_n != 4'hF) begin
      o_addr_seen <= i_data_out;
    end
  end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the expansion bus master.
// Assumes a peripheral model on the bus side and a free bus clock.
`timescale 1ns/100ps
module testbench;
  import ebs_pkg::*;
  localparam int SC = 6; // Long strobe so a stall lands inside it

  logic        clk, rst_b, bclk, valid, ready, done;
  logic        rs_n, ws_n, ale, oe, wait_n;
  ebs_req_t    req;
  logic [15:0] rdata, dout, pins, rd_word, wr_seen, addr_seen;
  logic [3:0]  sel_n, sel_seen;
  logic [7:0]  stall, scyc;
  int          err_count;
  int          n_checks;

  // Core clock 100 ns; bus clock 125 ns with an unrelated phase
  always #50 clk = ~clk;
  initial begin
    bclk = 1'b0;
    #37;
    forever #62.5 bclk = ~bclk;
  end

  ebs_bus_master #(.STROBE_CYCLES(SC)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_req_valid(valid), .i_req(req),
    .o_req_ready(ready), .o_done(done), .o_rdata(rdata),
    .i_bus_clock_in(bclk), .o_bus_select_n(sel_n),
    .o_bus_read_strobe_n(rs_n), .o_bus_write_strobe_n(ws_n),
    .o_bus_addr_latch(ale), .i_bus_data(pins), .o_bus_data(dout),
    .o_bus_data_oe(oe), .i_bus_wait_n(wait_n));

  ebs_periph_model peer (
    .i_bus_clock_in(bclk), .i_select_n(sel_n), .i_read_strobe_n(rs_n),
    .i_write_strobe_n(ws_n), .i_addr_latch(ale), .i_data_out(dout),
    .i_data_oe(oe), .i_rd_word(rd_word), .i_stall_len(stall),
    .o_data_pins(pins), .o_wait_n(wait_n), .o_strobe_cycles(scyc),
    .o_select_seen(sel_seen), .o_write_seen(wr_seen),
    .o_addr_seen(addr_seen));

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // One access: offer at a falling edge, then wait for done, bounded
  task automatic access(input ebs_req_t r);
    int n;
    @(negedge clk);
    req = r;
    valid = 1'b1;
    for (n = 0; ready !== 1'b1; n++) begin
      if (n > 100) begin
        chk("ready", 16'h0001, 16'h0000);
        close_out();
      end
      @(negedge clk);
    end
    @(negedge clk);
    valid = 1'b0;
    for (n = 0; done !== 1'b1; n++) begin
      if (n > 400) begin
        chk("done", 16'h0001, 16'h0000);
        close_out();
      end
      @(negedge clk);
    end
  endtask

  // Pin levels while reset is held
  task automatic t_reset;
    chk("rst select", 16'h000F, {12'h000, sel_n});
    chk("rst strobes", 16'h0003, {14'h0000, rs_n, ws_n});
    chk("rst data", 16'hFFFF, dout);
    chk("rst oe", 16'h0001, {15'h0000, oe});
    chk("rst latch", 16'h0001, {15'h0000, ale});
    $display("test reset done");
  endtask

  // Plain read through every chip select
  task automatic t_read_sel;
    for (int i = 0; i < 4; i++) begin
      rd_word = 16'hA5C0 + 16'(i);
      access('{1'b0, 1'b0, 2'(i), STYLE_SEPARATE, 16'h0000, 16'h0000});
      chk("rdata", rd_word, rdata);
      chk("select", 16'h000F ^ (16'h0001 << i), {12'h000, sel_seen});
      chk("strobe len", 16'(SC), {8'h00, scyc});
    end
    $display("test read_sel done");
  endtask

  // Muxed write in every style: address phase, then data
  task automatic t_write_all;
    for (int s = 0; s < 3; s++) begin
      access('{1'b1, 1'b1, 2'(s), ebs_style_t'(s), 16'h1230 + 16'(s),
               16'hBEE0 + 16'(s)});
      chk("wdata", 16'hBEE0 + 16'(s), wr_seen);
      chk("addr", 16'h1230 + 16'(s), addr_seen);
    end
    $display("test write_all done");
  endtask

  // Stall mid-strobe; only separate and combined styles stretch
  task automatic t_wait;
    stall = 8'h05;
    for (int s = 0; s < 3; s++) begin
      rd_word = 16'h5A00 + 16'(s);
      access('{1'b0, 1'b0, 2'(s), ebs_style_t'(s), 16'h0040, 16'h0000});
      chk("stall rdata", rd_word, rdata);
      chk("stall len", 16'(SC + (s < 2 ? 5 : 0)), {8'h00, scyc});
    end
    stall = 8'h00;
    $display("test wait done");
  endtask

  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    valid = 1'b0;
    req = '0;
    rd_word = 16'h0000;
    stall = 8'h00;
    err_count = 0;
    n_checks = 0;
    repeat (5) @(negedge clk);
    t_reset();
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    // Link reset needs a few bus clocks to release
    repeat (5) @(negedge clk);
    t_read_sel();
    t_write_all();
    t_wait();
    close_out();
  end
endmodule
